// File: verilog/line_event_cfg.svh
// Offsets, field positions, reset values and counts of the line event encoder.
// Assumes inclusion by bare name from the encoder module; the package does not include it.
`ifndef LINE_EVENT_CFG_SVH
`define LINE_EVENT_CFG_SVH
`define OFS_RX_EVENT 8'h00
`define OFS_TX_STATUS 8'h04
`define OFS_SECONDARY_SELECT 8'h08
`define OFS_LINE_CONTROL 8'h0C
`define OFS_EVENT_FLAGS 8'h10
`define OFS_LINE_READBACK 8'h14
`define POS_TX_CODE 8
`define POS_LCW_BUSY 15
`define POS_FLAG_RX 0
`define POS_FLAG_TX 1
`define RST_SECONDARY_SELECT 16'h0000
`define RST_RX_EVENT 16'h0000
`define RST_TX_CODE 4'h0
`define LCW_LOAD_TIME_NS 400
`define CLK_PERIOD_NS 100
`define LCW_LOAD_CYCLES ((`LCW_LOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: verilog/line_event_pkg.sv
// Types shared by the line event encoder and its control storage.
// Assumes the configuration header sits beside this file.
package line_event_pkg;
    typedef enum logic [3:0] {
        RX_SPECIAL = 4'h0, RX_PARITY = 4'h1, RX_OVERRUN = 4'h2, RX_FRAMING = 4'h3,
        RX_COUNT_WARN = 4'h4, RX_CHECK_DONE = 4'h5, RX_COUNT_ZERO = 4'h8,
        RX_STORE_NXM = 4'hC, RX_FETCH_NXM = 4'hD, RX_STORE_MPE = 4'hE,
        RX_FETCH_MPE = 4'hF
    } rx_code_type;
    typedef enum logic [3:0] {
        TX_PRI_NXM = 4'h0, TX_PRI_ZERO = 4'h1, TX_ALT_NXM = 4'h2, TX_ALT_ZERO = 4'h3,
        TX_FETCH_FAIL = 4'h8
    } tx_code_type;
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00, LD_WAIT = 2'b01, LD_COMMIT = 2'b11
    } load_state_type;
    typedef logic [3:0] line_type;
    typedef logic [14:0] lcw_type;
endpackage

// File: verilog/line_store_if.sv
// Carrier between the encoder and its per-line control storage.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface line_store_if;
    import line_event_pkg::*;
    logic we;
    line_type waddr;
    lcw_type wdata;
    line_type raddr;
    lcw_type rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: verilog/line_ctrl_store.sv
// Sixteen words of line control storage, one per data line.
// Assumes a synchronous write port and a registered read port.
`timescale 1ns/1ps
module line_ctrl_store (
    input wire logic clk_in,
    input wire logic rst_n_in,
    line_store_if.mem store
);
    import line_event_pkg::*;
    lcw_type mem_q [16];
    lcw_type rdata_q;
    always_ff @(posedge clk_in) begin
        if (store.we) begin
            mem_q[store.waddr] <= store.wdata;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 15'h0000;
        end else begin
            rdata_q <= mem_q[store.raddr];
        end
    end
    assign store.rdata = rdata_q;
endmodule

// File: verilog/line_event_code_encoder.sv
// Event code encoder of a sixteen-line communications multiplexer.
// Assumes event inputs synchronous to CLK_IN and an AXI4-Lite master.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "line_event_cfg.svh"
module line_event_code_encoder (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [7:0] AXI_AWADDR_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    output logic [1:0] AXI_BRESP_OUT,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    input wire logic [7:0] AXI_ARADDR_IN,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    input wire logic RX_VALID_IN,
    input wire logic [7:0] RX_CHAR_IN,
    input wire line_event_pkg::line_type RX_LINE_IN,
    input wire logic RX_ASYNC_IN,
    input wire logic RX_SPECIAL_IN,
    input wire logic RX_PARITY_ERR_IN,
    input wire logic RX_OVERRUN_IN,
    input wire logic RX_FRAMING_IN,
    input wire logic RX_COUNT_ZERO_IN,
    input wire logic RX_COUNT_LAST_IN,
    input wire logic RX_CHECK_DONE_IN,
    input wire logic [15:0] RX_CHECK_VALUE_IN,
    input wire logic RX_STORE_NXM_IN,
    input wire logic RX_FETCH_NXM_IN,
    input wire logic RX_STORE_MPE_IN,
    input wire logic RX_FETCH_MPE_IN,
    output logic RX_STORE_OUT,
    output logic [15:0] RX_CHECK_HOLD_OUT,
    input wire logic TX_VALID_IN,
    input wire line_event_pkg::tx_code_type TX_KIND_IN,
    input wire line_event_pkg::line_type TX_LINE_IN,
    input wire logic TX_FETCH_MPE_IN,
    output logic TX_CAUSE_VALID_OUT,
    output line_event_pkg::line_type TX_CAUSE_LINE_OUT,
    output logic TX_CAUSE_MPE_OUT,
    output logic LC_LOAD_OUT,
    output line_event_pkg::line_type LC_LINE_OUT,
    output line_event_pkg::lcw_type LC_DATA_OUT
);
    import line_event_pkg::*;

    // Reset release through two flip-flops; only the second copy is used.
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // Receive code with priority: memory faults, count zero, line errors, block events.
    function automatic rx_code_type rx_code_f(input logic async_line, input logic par,
                                              input logic ovr, input logic frm);
        rx_code_type code;
        code = RX_SPECIAL;
        if (async_line) begin
            if (ovr) begin
                code = RX_OVERRUN;
            end else if (frm) begin
                code = RX_FRAMING;
            end else if (par) begin
                code = RX_PARITY;
            end
        end else begin
            // Synchronous lines keep the combined parity and overrun code.
            code = rx_code_type'({2'b00, ovr, par});
        end
        return code;
    endfunction

    function automatic logic [15:0] merge_f(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Receive event capture.
    logic rx_line_err;
    logic rx_raise;
    rx_code_type rx_code;
    logic [7:0] rx_char_sel;
    logic [15:0] rx_word_q, rx_word_d;
    logic [15:0] check_hold_q, check_hold_d;
    always_comb begin
        rx_line_err = RX_PARITY_ERR_IN | RX_OVERRUN_IN | (RX_FRAMING_IN & RX_ASYNC_IN);
        rx_code = RX_SPECIAL;
        rx_raise = 1'b1;
        rx_char_sel = RX_CHAR_IN;
        if (RX_FETCH_MPE_IN) begin
            rx_code = RX_FETCH_MPE;
        end else if (RX_FETCH_NXM_IN) begin
            rx_code = RX_FETCH_NXM;
        end else if (RX_STORE_MPE_IN) begin
            rx_code = RX_STORE_MPE;
        end else if (RX_STORE_NXM_IN) begin
            rx_code = RX_STORE_NXM;
        end else if (RX_COUNT_ZERO_IN) begin
            rx_code = RX_COUNT_ZERO;
        end else if (rx_line_err) begin
            rx_code = rx_code_f(RX_ASYNC_IN, RX_PARITY_ERR_IN, RX_OVERRUN_IN,
                                RX_FRAMING_IN);
        end else if (RX_CHECK_DONE_IN) begin
            rx_code = RX_CHECK_DONE;
            rx_char_sel = RX_CHECK_VALUE_IN[15:8] | RX_CHECK_VALUE_IN[7:0];
        end else if (RX_COUNT_LAST_IN) begin
            rx_code = RX_COUNT_WARN;
        end else if (RX_SPECIAL_IN) begin
            rx_code = RX_SPECIAL;
        end else begin
            rx_raise = 1'b0;
        end
        rx_raise = rx_raise & RX_VALID_IN;
        rx_word_d = rx_word_q;
        if (rx_raise) begin
            rx_word_d = {rx_code, RX_LINE_IN, rx_char_sel};
        end
        check_hold_d = check_hold_q;
        if (RX_VALID_IN && RX_CHECK_DONE_IN) begin
            check_hold_d = RX_CHECK_VALUE_IN;
        end
    end
    // A character is written to memory only while its line still has room.
    assign RX_STORE_OUT = RX_VALID_IN & ~RX_COUNT_ZERO_IN;
    assign RX_CHECK_HOLD_OUT = check_hold_q;

    // Transmit event capture; kinds outside the five defined codes are dropped.
    logic tx_legal;
    logic tx_raise;
    tx_code_type tx_code_q, tx_code_d;
    logic tx_cause_valid_q, tx_cause_valid_d;
    line_type tx_cause_line_q, tx_cause_line_d;
    logic tx_cause_mpe_q, tx_cause_mpe_d;
    always_comb begin
        tx_legal = (TX_KIND_IN == TX_PRI_NXM) || (TX_KIND_IN == TX_PRI_ZERO) ||
                   (TX_KIND_IN == TX_ALT_NXM) || (TX_KIND_IN == TX_ALT_ZERO) ||
                   (TX_KIND_IN == TX_FETCH_FAIL);
        tx_raise = TX_VALID_IN & tx_legal;
        tx_code_d = tx_code_q;
        if (tx_raise) begin
            tx_code_d = TX_KIND_IN;
        end
        tx_cause_valid_d = tx_raise && (TX_KIND_IN == TX_FETCH_FAIL);
        tx_cause_line_d = tx_cause_valid_d ? TX_LINE_IN : tx_cause_line_q;
        tx_cause_mpe_d = tx_cause_valid_d ? TX_FETCH_MPE_IN : tx_cause_mpe_q;
    end
    assign TX_CAUSE_VALID_OUT = tx_cause_valid_q;
    assign TX_CAUSE_LINE_OUT = tx_cause_line_q;
    assign TX_CAUSE_MPE_OUT = tx_cause_mpe_q;

    // Register bus slave.
    logic aw_full_q, aw_full_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic w_full_q, w_full_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic wr_fire;
    logic [15:0] sel_q, sel_d;
    lcw_type lcw_q, lcw_d;
    line_type load_line_q, load_line_d;
    load_state_type ld_state_q, ld_state_d;
    logic [3:0] ld_cnt_q, ld_cnt_d;
    logic lc_load_q, lc_load_d;
    logic flag_rx_q, flag_rx_d;
    logic flag_tx_q, flag_tx_d;
    logic ld_busy;
    line_store_if store ();

    assign ld_busy = ld_state_q != LD_IDLE;
    assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
    assign AXI_AWREADY_OUT = ~aw_full_q & ~bvalid_q;
    assign AXI_WREADY_OUT = ~w_full_q & ~bvalid_q;
    assign AXI_ARREADY_OUT = ~rvalid_q;
    assign AXI_BVALID_OUT = bvalid_q;
    assign AXI_BRESP_OUT = bresp_q;
    assign AXI_RVALID_OUT = rvalid_q;
    assign AXI_RDATA_OUT = rdata_q;
    assign AXI_RRESP_OUT = rresp_q;

    always_comb begin
        aw_full_d = aw_full_q;
        awaddr_d = awaddr_q;
        w_full_d = w_full_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        sel_d = sel_q;
        lcw_d = lcw_q;
        flag_rx_d = flag_rx_q;
        flag_tx_d = flag_tx_q;
        ld_state_d = ld_state_q;
        ld_cnt_d = ld_cnt_q;
        load_line_d = load_line_q;
        lc_load_d = 1'b0;
        if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
            aw_full_d = 1'b1;
            awaddr_d = AXI_AWADDR_IN;
        end
        if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
            w_full_d = 1'b1;
            wdata_d = AXI_WDATA_IN;
            wstrb_d = AXI_WSTRB_IN;
        end
        if (bvalid_q && AXI_BREADY_IN) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `RESP_OKAY;
            if (awaddr_q == `OFS_SECONDARY_SELECT) begin
                sel_d = merge_f(sel_q, wdata_q, wstrb_q);
            end else if (awaddr_q == `OFS_LINE_CONTROL) begin
                // A write while a load is pending is ignored.
                if (!ld_busy && wstrb_q[1:0] == 2'b11) begin
                    lcw_d = wdata_q[14:0];
                    ld_state_d = LD_WAIT;
                    ld_cnt_d = 4'(`LCW_LOAD_CYCLES - 1);
                    load_line_d = sel_q[3:0];
                end
            end else if (awaddr_q == `OFS_EVENT_FLAGS) begin
                if (wstrb_q[0] && wdata_q[`POS_FLAG_RX]) begin
                    flag_rx_d = 1'b0;
                end
                if (wstrb_q[0] && wdata_q[`POS_FLAG_TX]) begin
                    flag_tx_d = 1'b0;
                end
            end else if (awaddr_q == `OFS_RX_EVENT || awaddr_q == `OFS_TX_STATUS ||
                         awaddr_q == `OFS_LINE_READBACK) begin
                bresp_d = `RESP_OKAY;
            end else begin
                bresp_d = `RESP_SLVERR;
            end
        end
        // New events win over a clear in the same cycle.
        if (rx_raise) begin
            flag_rx_d = 1'b1;
        end
        if (tx_raise) begin
            flag_tx_d = 1'b1;
        end
        case (ld_state_q)
            LD_WAIT: begin
                if (ld_cnt_q == 4'h0) begin
                    ld_state_d = LD_COMMIT;
                    lc_load_d = 1'b1;
                end else begin
                    ld_cnt_d = ld_cnt_q - 4'h1;
                end
            end
            LD_COMMIT: begin
                ld_state_d = LD_IDLE;
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && AXI_RREADY_IN) begin
            rvalid_d = 1'b0;
        end
        if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
            rvalid_d = 1'b1;
            rresp_d = `RESP_OKAY;
            rdata_d = 32'h00000000;
            if (AXI_ARADDR_IN == `OFS_RX_EVENT) begin
                rdata_d = {16'h0000, rx_word_q};
            end else if (AXI_ARADDR_IN == `OFS_TX_STATUS) begin
                rdata_d[`POS_TX_CODE +: 4] = tx_code_q;
            end else if (AXI_ARADDR_IN == `OFS_SECONDARY_SELECT) begin
                rdata_d = {16'h0000, sel_q};
            end else if (AXI_ARADDR_IN == `OFS_LINE_CONTROL) begin
                rdata_d = {16'h0000, ld_busy, lcw_q};
            end else if (AXI_ARADDR_IN == `OFS_EVENT_FLAGS) begin
                rdata_d = {30'h00000000, flag_tx_q, flag_rx_q};
            end else if (AXI_ARADDR_IN == `OFS_LINE_READBACK) begin
                rdata_d = {17'h00000, store.rdata};
            end else begin
                rresp_d = `RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_full_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `RESP_OKAY;
            sel_q <= `RST_SECONDARY_SELECT;
            lcw_q <= 15'h0000;
            load_line_q <= 4'h0;
            ld_state_q <= LD_IDLE;
            ld_cnt_q <= 4'h0;
            lc_load_q <= 1'b0;
            flag_rx_q <= 1'b0;
            flag_tx_q <= 1'b0;
            rx_word_q <= `RST_RX_EVENT;
            check_hold_q <= 16'h0000;
            tx_code_q <= tx_code_type'(`RST_TX_CODE);
            tx_cause_valid_q <= 1'b0;
            tx_cause_line_q <= 4'h0;
            tx_cause_mpe_q <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            awaddr_q <= awaddr_d;
            w_full_q <= w_full_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            sel_q <= sel_d;
            lcw_q <= lcw_d;
            load_line_q <= load_line_d;
            ld_state_q <= ld_state_d;
            ld_cnt_q <= ld_cnt_d;
            lc_load_q <= lc_load_d;
            flag_rx_q <= flag_rx_d;
            flag_tx_q <= flag_tx_d;
            rx_word_q <= rx_word_d;
            check_hold_q <= check_hold_d;
            tx_code_q <= tx_code_d;
            tx_cause_valid_q <= tx_cause_valid_d;
            tx_cause_line_q <= tx_cause_line_d;
            tx_cause_mpe_q <= tx_cause_mpe_d;
        end
    end

    assign LC_LOAD_OUT = lc_load_q;
    assign LC_LINE_OUT = load_line_q;
    assign LC_DATA_OUT = lcw_q;
    // The loaded word lands in the storage of the selected line.
    assign store.we = lc_load_q;
    assign store.waddr = load_line_q;
    assign store.wdata = lcw_q;
    assign store.raddr = sel_q[3:0];

    line_ctrl_store line_ctrl_store_inst (
        .clk_in(CLK_IN),
        .rst_n_in(rst_n),
        .store(store.mem)
    );

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!rst_n);

    sequence lcw_write_s;
        wr_fire && awaddr_q == `OFS_LINE_CONTROL && !ld_busy && wstrb_q[1:0] == 2'b11;
    endsequence
    sequence load_pulse_s;
        LC_LOAD_OUT && LC_LINE_OUT == $past(sel_q[3:0], 5);
    endsequence

    chk_word_layout: assert property (rx_raise |=> rx_word_q[11:8] == $past(RX_LINE_IN))
        else $error("receive word line field wrong");
    chk_fetch_parity: assert property (RX_VALID_IN && RX_FETCH_MPE_IN |=>
        rx_word_q[15:12] == 4'hF && flag_rx_q)
        else $error("fetch parity code wrong");
    chk_count_zero: assert property (RX_VALID_IN && RX_COUNT_ZERO_IN && !RX_STORE_NXM_IN &&
        !RX_FETCH_NXM_IN && !RX_STORE_MPE_IN && !RX_FETCH_MPE_IN |->
        !RX_STORE_OUT ##1 rx_word_q[15:12] == 4'h8)
        else $error("count zero handling wrong");
    chk_async_overrun: assert property (RX_VALID_IN && RX_ASYNC_IN && RX_OVERRUN_IN &&
        rx_code < RX_COUNT_WARN |=> rx_word_q[15:12] == 4'h2)
        else $error("async overrun not dominant");
    chk_async_framing: assert property (RX_VALID_IN && RX_ASYNC_IN && RX_FRAMING_IN &&
        RX_PARITY_ERR_IN && !RX_OVERRUN_IN && rx_code < RX_COUNT_WARN |=>
        rx_word_q[15:12] == 4'h3)
        else $error("async framing not over parity");
    chk_sync_combined: assert property (RX_VALID_IN && !RX_ASYNC_IN && RX_OVERRUN_IN &&
        RX_PARITY_ERR_IN && rx_code < RX_COUNT_WARN |=> rx_word_q[15:12] == 4'h3)
        else $error("sync combined code lost");
    chk_check_or: assert property (rx_raise && rx_code == RX_CHECK_DONE |=>
        rx_word_q[7:0] == ($past(RX_CHECK_VALUE_IN[15:8]) | $past(RX_CHECK_VALUE_IN[7:0]))
        && RX_CHECK_HOLD_OUT == $past(RX_CHECK_VALUE_IN))
        else $error("check complete word wrong");
    chk_rx_code_legal: assert property (!(rx_word_q[15:12] inside {4'h6, 4'h7, 4'h9, 4'hA,
        4'hB}))
        else $error("undefined receive code");
    chk_tx_code_legal: assert property (tx_code_q inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8})
        else $error("undefined transmit code");
    chk_tx_fetch_cause: assert property (TX_VALID_IN && TX_KIND_IN == TX_FETCH_FAIL |=>
        TX_CAUSE_VALID_OUT && tx_code_q == TX_FETCH_FAIL &&
        TX_CAUSE_MPE_OUT == $past(TX_FETCH_MPE_IN))
        else $error("transmit fetch cause lost");
    chk_load_line: assert property (lcw_write_s |-> ##5 load_pulse_s ##1 !ld_busy)
        else $error("line control load misrouted");
endmodule

// File: tb/rx_source_model.sv
// Far-side receive datapath model: presents one character event per request.
// Assumes requests are driven by non-blocking assignment at the rising edge.
`timescale 1ns/1ps
module rx_source_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [11:0] flags_in,
    input wire logic [7:0] char_in,
    input wire logic [3:0] line_in,
    output logic valid_out,
    output logic [11:0] flags_out,
    output logic [7:0] char_out,
    output logic [3:0] line_out
);
    // Qualifiers are not held between events, so they toggle to expose stale sampling.
    always_ff @(posedge clk_in) begin
        valid_out <= go_in;
        flags_out <= go_in ? flags_in : ~flags_out;
        char_out <= go_in ? char_in : ~char_out;
        line_out <= go_in ? line_in : ~line_out;
    end
endmodule

// File: tb/line_event_code_encoder_tb.sv
// Self-checking bench of the line event code encoder.
// Assumes the design package, interface, storage and partner model are compiled first.
`timescale 1ns/1ps
module line_event_code_encoder_tb;
    import line_event_pkg::*;
    logic CLK_IN, AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT;
    logic AXI_RVALID_OUT, RX_STORE_OUT, TX_CAUSE_VALID_OUT, TX_CAUSE_MPE_OUT, LC_LOAD_OUT;
    logic [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT;
    logic [31:0] AXI_RDATA_OUT;
    logic [15:0] RX_CHECK_HOLD_OUT;
    line_type TX_CAUSE_LINE_OUT, LC_LINE_OUT, RX_LINE_IN;
    lcw_type LC_DATA_OUT;
    logic RX_VALID_IN, RX_ASYNC_IN, RX_SPECIAL_IN, RX_PARITY_ERR_IN, RX_OVERRUN_IN;
    logic RX_FRAMING_IN, RX_COUNT_ZERO_IN, RX_COUNT_LAST_IN, RX_CHECK_DONE_IN;
    logic RX_STORE_NXM_IN, RX_FETCH_NXM_IN, RX_STORE_MPE_IN, RX_FETCH_MPE_IN;
    logic [7:0] RX_CHAR_IN;
    logic [11:0] pf;
    logic [1:0] br;
    logic RESET_N_IN = 0, AXI_AWVALID_IN = 0, AXI_WVALID_IN = 0, AXI_BREADY_IN = 0;
    logic AXI_ARVALID_IN = 0, AXI_RREADY_IN = 0, TX_VALID_IN = 0, go = 0, TX_FETCH_MPE_IN = 0;
    logic [7:0] AXI_AWADDR_IN = '0, AXI_ARADDR_IN = '0, ch = '0;
    logic [31:0] AXI_WDATA_IN = '0;
    line_type TX_LINE_IN = '0, ln = '0;
    tx_code_type TX_KIND_IN = TX_PRI_NXM;
    logic [11:0] fl = '0;
    wire logic [3:0] AXI_WSTRB_IN = 4'hF;
    wire logic [15:0] RX_CHECK_VALUE_IN = 16'h3C05;
    int fail_count = 0, checks = 0, cyc = 0;
    logic [11:0] fls [15] = '{12'hC00, 12'hA00, 12'h900, 12'h880, 12'h820, 12'h810, 12'h840,
        12'h808, 12'h804, 12'h802, 12'h801, 12'hB80, 12'hA80, 12'h300, 12'h200};
    logic [3:0] cds [15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hC, 4'hD, 4'hE,
        4'hF, 4'h2, 4'h3, 4'h3, 4'h1};
    logic [3:0] kinds [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h5, 4'h8};
    assign {RX_ASYNC_IN, RX_SPECIAL_IN, RX_PARITY_ERR_IN, RX_OVERRUN_IN, RX_FRAMING_IN,
        RX_COUNT_ZERO_IN, RX_COUNT_LAST_IN, RX_CHECK_DONE_IN, RX_STORE_NXM_IN,
        RX_FETCH_NXM_IN, RX_STORE_MPE_IN, RX_FETCH_MPE_IN} = pf;
    line_event_code_encoder line_event_code_encoder_inst (.*);
    rx_source_model rx_source_model_inst (.clk_in(CLK_IN), .go_in(go), .flags_in(fl),
        .char_in(ch), .line_in(ln), .valid_out(RX_VALID_IN), .flags_out(pf),
        .char_out(RX_CHAR_IN), .line_out(RX_LINE_IN));
    initial begin
        CLK_IN = 1'b0;
        forever #50 CLK_IN = ~CLK_IN;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge CLK_IN) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, b;
        @(posedge CLK_IN);
        AXI_AWADDR_IN <= a;
        AXI_WDATA_IN <= d;
        AXI_AWVALID_IN <= 1'b1;
        AXI_WVALID_IN <= 1'b1;
        AXI_BREADY_IN <= 1'b1;
        do begin
            @(negedge CLK_IN);
            ta = AXI_AWVALID_IN && AXI_AWREADY_OUT;
            tw = AXI_WVALID_IN && AXI_WREADY_OUT;
            b = AXI_BVALID_OUT;
            br = AXI_BRESP_OUT;
            @(posedge CLK_IN);
            if (ta) AXI_AWVALID_IN <= 1'b0;
            if (tw) AXI_WVALID_IN <= 1'b0;
        end while (b !== 1'b1);
        AXI_BREADY_IN <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t, v;
        @(posedge CLK_IN);
        AXI_ARADDR_IN <= a;
        AXI_ARVALID_IN <= 1'b1;
        AXI_RREADY_IN <= 1'b1;
        do begin
            @(negedge CLK_IN);
            t = AXI_ARVALID_IN && AXI_ARREADY_OUT;
            v = AXI_RVALID_OUT;
            d = AXI_RDATA_OUT;
            r = AXI_RRESP_OUT;
            @(posedge CLK_IN);
            if (t) AXI_ARVALID_IN <= 1'b0;
        end while (v !== 1'b1);
        AXI_RREADY_IN <= 1'b0;
    endtask
    task automatic rx_test();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 15; i++) begin
            @(posedge CLK_IN);
            go <= 1'b1;
            fl <= fls[i];
            ch <= 8'hA0 + i[7:0];
            ln <= i[3:0];
            @(posedge CLK_IN);
            go <= 1'b0;
            @(negedge CLK_IN);
            chk(RX_STORE_OUT, !fls[i][6]);
            rd(8'h00, d, r);
            chk(d[15:0], {cds[i], i[3:0], fls[i][4] ? 8'h3D : 8'hA0 + i[7:0]});
        end
        chk(RX_CHECK_HOLD_OUT, 16'h3C05);
        $display("receive test done");
    endtask
    task automatic tx_test();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 7; i++) begin
            @(posedge CLK_IN);
            TX_VALID_IN <= 1'b1;
            TX_KIND_IN <= tx_code_type'(kinds[i]);
            TX_LINE_IN <= i[3:0];
            TX_FETCH_MPE_IN <= i[1];
            @(posedge CLK_IN);
            TX_VALID_IN <= 1'b0;
            @(negedge CLK_IN);
            chk(TX_CAUSE_VALID_OUT, kinds[i] == 4'h8);
            if (kinds[i] == 4'h8) begin
                chk({TX_CAUSE_LINE_OUT, TX_CAUSE_MPE_OUT}, {i[3:0], i[1]});
            end
            rd(8'h04, d, r);
            chk(d[11:8], i < 5 ? kinds[i] : 4'h8);
        end
        chk({TX_CAUSE_LINE_OUT, TX_CAUSE_MPE_OUT}, 5'h0D);
        $display("transmit test done");
    endtask
    task automatic flag_test();
        logic [31:0] d;
        logic [1:0] r;
        rd(8'h10, d, r);
        chk(d, 32'h00000003);
        wr(8'h10, 32'h00000001);
        chk(br, 2'h0);
        rd(8'h10, d, r);
        chk(d, 32'h00000002);
        wr(8'h50, 32'h00000001);
        chk(br, 2'h2);
        $display("event flag test done");
    endtask
    task automatic lc_test();
        logic [31:0] d;
        logic [1:0] r;
        int n = 0;
        wr(8'h08, 32'h0000_0009);
        chk(br, 2'h0);
        wr(8'h0C, 32'h0000_1234);
        do begin
            @(negedge CLK_IN);
            n++;
        end while (LC_LOAD_OUT !== 1'b1 && n < 20);
        chk({LC_LOAD_OUT, LC_LINE_OUT, LC_DATA_OUT}, {1'b1, 4'h9, 15'h1234});
        do rd(8'h0C, d, r); while (d[15] !== 1'b0);
        rd(8'h14, d, r);
        chk(d[14:0], 15'h1234);
        rd(8'h40, d, r);
        chk({r, d}, {2'h2, 32'h0});
        $display("line control test done");
    endtask
    initial begin
        repeat (8) @(posedge CLK_IN);
        RESET_N_IN <= 1'b1;
        repeat (2) @(posedge CLK_IN);
        rx_test();
        tx_test();
        flag_test();
        lc_test();
        print_verdict();
    end
endmodule
